// ### logic/mot_regs.sv
// Summary of operation
// - Upper and lower margin voltages are the nominal setpoint plus and minus the stored percentage, only while margining is enabled.
// - The margin percentage is a per-output 16-bit read/write linear word covering zero to fifty percent.
// - After reset the margin percentage reads back as five percent, word CA80h.
// - With bit 7 of the fault configuration set an over-voltage shutdown turns the low-side device on, otherwise it stays off.
// - A fault response starts only after N+1 consecutive violations, N being bits 3:0 of the fault configuration.
// - The fault configuration is a per-output read/write byte resetting to 00h whose bits 6:4 always read zero.
// - The reported external temperature is the raw sensor temperature divided by the scale plus the offset, scales 0.1 to 10.
// - The temperature scale is a per-output 16-bit read/write linear word resetting to BA00h, a scale of one.
// - The temperature offset is a per-output linear word resetting to zero, valid from -100 to 100.
`timescale 1ns/10ps
`default_nettype none
module mot_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // decoded command port
  input wire mot_pkg::mot_cmd_s cmd,
  output mot_pkg::mot_rsp_s rsp,
  // margining
  input wire logic [1:0] margin_enable,
  input wire logic [1:0][15:0] nominal_setpoint,
  output logic [1:0][15:0] upper_margin_voltage,
  output logic [1:0][15:0] lower_margin_voltage,
  // voltage fault detection
  input wire logic [1:0] limit_sample_en,
  input wire logic [1:0] ov_violation,
  input wire logic [1:0] uv_violation,
  input wire logic [1:0] shutdown_clear,
  output logic [1:0] ov_fault,
  output logic [1:0] uv_fault,
  output logic [1:0] low_side_on,
  // external temperature
  input wire logic [1:0][15:0] external_sensor_temperature,
  output logic [1:0][15:0] external_temp_report
);

  ////////////////////////////////////////////////////////////////////////
  // storage, indexed by page

  logic [1:0][15:0] output_margin_percent_reg;
  logic [1:0][7:0] overvolt_undervolt_fault_config_reg;
  logic [1:0][15:0] external_temp_scale_reg;
  logic [1:0][15:0] external_temp_offset_reg;

  wire logic page_all;
  wire logic page_idx;
  wire logic page_ok;
  wire logic code_known;
  wire logic [1:0] wr_page;
  wire logic [15:0] rd_value;

  assign page_all = (cmd.page == mot_pkg::PAGE_ALL);
  assign page_idx = page_all ? 1'b0 : cmd.page[0];
  assign page_ok = page_all || (cmd.page < 8'(mot_pkg::NUM_PAGES));
  assign code_known = (cmd.code == mot_pkg::CMD_MARGIN_PCT) || (cmd.code == mot_pkg::CMD_OVUV_CFG)
                   || (cmd.code == mot_pkg::CMD_XT_SCALE) || (cmd.code == mot_pkg::CMD_XT_OFFSET);
  // all-pages writes both outputs; reads from all-pages see output 0
  assign wr_page = page_all ? 2'h3 : (page_idx ? 2'h2 : 2'h1);

  assign rd_value = (cmd.code == mot_pkg::CMD_MARGIN_PCT) ? output_margin_percent_reg[page_idx] :
                    (cmd.code == mot_pkg::CMD_OVUV_CFG) ?
                      {8'h00, overvolt_undervolt_fault_config_reg[page_idx]} :
                    (cmd.code == mot_pkg::CMD_XT_SCALE) ? external_temp_scale_reg[page_idx] :
                    (cmd.code == mot_pkg::CMD_XT_OFFSET) ? external_temp_offset_reg[page_idx] :
                    16'h0000;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < mot_pkg::NUM_PAGES; p++)
      begin
        output_margin_percent_reg[p] <= mot_pkg::MARGIN_PCT_RST;
        overvolt_undervolt_fault_config_reg[p] <= mot_pkg::OVUV_CFG_RST;
        external_temp_scale_reg[p] <= mot_pkg::XT_SCALE_RST;
        external_temp_offset_reg[p] <= mot_pkg::XT_OFFSET_RST;
      end
    end
    else if (cmd.wr && page_ok)
    begin
      for (int p = 0; p < mot_pkg::NUM_PAGES; p++)
      begin
        if (wr_page[p])
        begin
          if (cmd.code == mot_pkg::CMD_MARGIN_PCT)
            output_margin_percent_reg[p] <= cmd.data;
          if (cmd.code == mot_pkg::CMD_OVUV_CFG)
            overvolt_undervolt_fault_config_reg[p] <= cmd.data[7:0] & mot_pkg::OVUV_WRITE_MASK;
          if (cmd.code == mot_pkg::CMD_XT_SCALE)
            external_temp_scale_reg[p] <= cmd.data;
          if (cmd.code == mot_pkg::CMD_XT_OFFSET)
            external_temp_offset_reg[p] <= cmd.data;
        end
      end
    end
  end

  // one answer cycle after each read or write; unknown code or page is refused
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rsp <= '0;
    else
    begin
      rsp.valid <= cmd.rd || cmd.wr;
      rsp.nack <= (cmd.rd || cmd.wr) && !(code_known && page_ok);
      rsp.data <= (cmd.rd && code_known && page_ok) ? rd_value : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-output arithmetic

  logic [1:0][15:0] upper_next;
  logic [1:0][15:0] lower_next;
  logic [1:0][15:0] temp_next;

  always_comb
  begin
    logic signed [47:0] nom;
    logic signed [47:0] delta;
    logic signed [47:0] half;
    logic signed [47:0] num;
    logic signed [47:0] quo;
    logic signed [47:0] offs;
    logic signed [4:0] e;
    logic signed [10:0] m;
    logic [4:0] sh;
    nom = '0;
    delta = '0;
    half = '0;
    num = '0;
    quo = '0;
    offs = '0;
    e = '0;
    m = '0;
    sh = '0;
    for (int p = 0; p < mot_pkg::NUM_PAGES; p++)
    begin
      // margin: percentage of nominal, held inside zero to half of nominal
      nom = 48'(nominal_setpoint[p]);
      delta = mot_pkg::lin11_apply(nom, output_margin_percent_reg[p]) / mot_pkg::PCT_DIVISOR;
      half = nom >>> 1;
      if (delta < 0)
        delta = '0;
      else if (delta > half)
        delta = half;
      if (margin_enable[p])
      begin
        upper_next[p] = 16'(nom + delta);
        lower_next[p] = 16'(nom - delta);
      end
      else
      begin
        upper_next[p] = nominal_setpoint[p];
        lower_next[p] = nominal_setpoint[p];
      end
      // temperature: raw times two to minus exponent, over mantissa, plus offset
      e = external_temp_scale_reg[p][mot_pkg::LIN_EXP_MSB:mot_pkg::LIN_EXP_LSB];
      m = external_temp_scale_reg[p][mot_pkg::LIN_MANT_MSB:0];
      sh = 5'(-e);
      num = 48'(signed'(external_sensor_temperature[p])) <<< mot_pkg::TEMP_GUARD;
      if (e[4])
        num = num <<< sh;
      else
        num = num >>> e[3:0];
      // a zero scale cannot divide; the raw reading passes unscaled
      if (m == '0)
        quo = 48'(signed'(external_sensor_temperature[p]));
      else
        quo = (num / 48'(m)) >>> mot_pkg::TEMP_GUARD;
      offs = mot_pkg::lin11_apply(mot_pkg::TEMP_ONE, external_temp_offset_reg[p]);
      temp_next[p] = 16'(quo + offs);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upper_margin_voltage <= '0;
      lower_margin_voltage <= '0;
      external_temp_report <= '0;
    end
    else
    begin
      upper_margin_voltage <= upper_next;
      lower_margin_voltage <= lower_next;
      external_temp_report <= temp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // voltage fault qualification and low-side state

  for (genvar g = 0; g < mot_pkg::NUM_PAGES; g++)
  begin : g_fault
    mot_violation_counter u_ov (
      .clk(clk),
      .rst_n(rst_n),
      .sample_en(limit_sample_en[g]),
      .violation(ov_violation[g]),
      .limit(overvolt_undervolt_fault_config_reg[g][mot_pkg::OVUV_COUNT_MSB:0]),
      .fault(ov_fault[g])
    );
    mot_violation_counter u_uv (
      .clk(clk),
      .rst_n(rst_n),
      .sample_en(limit_sample_en[g]),
      .violation(uv_violation[g]),
      .limit(overvolt_undervolt_fault_config_reg[g][mot_pkg::OVUV_COUNT_MSB:0]),
      .fault(uv_fault[g])
    );
  end

  // set wins over clear so a shutdown never slips past a restart
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      low_side_on <= 2'h0;
    else
    begin
      for (int p = 0; p < mot_pkg::NUM_PAGES; p++)
      begin
        if (ov_fault[p] && overvolt_undervolt_fault_config_reg[p][mot_pkg::OVUV_LOWSIDE_BIT])
          low_side_on[p] <= 1'b1;
        else if (shutdown_clear[p])
          low_side_on[p] <= 1'b0;
      end
    end
  end

endmodule : mot_regs
`default_nettype wire

// ### logic/mot_violation_counter.sv
`timescale 1ns/10ps
`default_nettype none
module mot_violation_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sampling
  input wire logic sample_en,
  input wire logic violation,
  input wire logic [3:0] limit,
  // result
  output logic fault
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic fired_reg;
  wire logic reached;

  // a violation sample makes count+1 consecutive hits
  assign cnt_next = (sample_en && violation) ? cnt_reg + 5'h01 : cnt_reg;
  assign reached = sample_en && violation && !fired_reg && (cnt_reg == {1'b0, limit});

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 5'h00;
      fired_reg <= 1'b0;
      fault <= 1'b0;
    end
    else
    begin
      fault <= reached;
      // a clean sample breaks the run; one response per run
      if (sample_en && !violation)
      begin
        cnt_reg <= 5'h00;
        fired_reg <= 1'b0;
      end
      else if (reached)
        fired_reg <= 1'b1;
      else if (!fired_reg)
        cnt_reg <= cnt_next;
    end
  end

endmodule : mot_violation_counter
`default_nettype wire

// ### pkg/mot_pkg.sv
`default_nettype none
package mot_pkg;

  // command codes
  localparam logic [7:0] CMD_MARGIN_PCT = 8'hD7;
  localparam logic [7:0] CMD_OVUV_CFG = 8'hD8;
  localparam logic [7:0] CMD_XT_SCALE = 8'hD9;
  localparam logic [7:0] CMD_XT_OFFSET = 8'hDA;
  localparam logic [7:0] PAGE_ALL = 8'hFF;

  // reset values
  localparam logic [15:0] MARGIN_PCT_RST = 16'hCA80;
  localparam logic [7:0] OVUV_CFG_RST = 8'h00;
  localparam logic [15:0] XT_SCALE_RST = 16'hBA00;
  localparam logic [15:0] XT_OFFSET_RST = 16'h0000;

  // linear word layout
  localparam int LIN_EXP_MSB = 15;
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_MANT_MSB = 10;

  // fault configuration byte layout
  localparam int OVUV_LOWSIDE_BIT = 7;
  localparam int OVUV_COUNT_MSB = 3;
  localparam logic [7:0] OVUV_WRITE_MASK = 8'h8F;

  // arithmetic
  localparam int NUM_PAGES = 2;
  localparam int TEMP_FRAC = 4;
  localparam int TEMP_GUARD = 8;
  localparam logic signed [47:0] PCT_DIVISOR = 48'sh64;
  localparam logic signed [47:0] TEMP_ONE = 48'sh10;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [7:0] code;
    logic [15:0] data;
  } mot_cmd_s;

  typedef struct packed {
    logic valid;
    logic nack;
    logic [15:0] data;
  } mot_rsp_s;

  // value times mantissa times two to the exponent of a linear word
  function automatic logic signed [47:0] lin11_apply(input logic signed [47:0] v,
                                                     input logic [15:0] w);
    logic signed [4:0] e;
    logic signed [10:0] m;
    logic signed [47:0] p;
    logic [4:0] sh;
    e = w[LIN_EXP_MSB:LIN_EXP_LSB];
    m = w[LIN_MANT_MSB:0];
    p = v * 48'(m);
    sh = 5'(-e);
    if (e[4])
      lin11_apply = p >>> sh;
    else
      lin11_apply = p <<< e[3:0];
  endfunction : lin11_apply

endpackage : mot_pkg
`default_nettype wire

// ### tb/mot_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mot_host_model (
  // clock
  input wire logic clk,
  // command port
  output mot_pkg::mot_cmd_s cmd,
  input wire mot_pkg::mot_rsp_s rsp
);
  initial cmd = '0;
  // data is inverted once released so a stale word can never pass for a fresh one
  task automatic xfer(input logic w, input logic [7:0] pg, input logic [7:0] cd,
                      input logic [15:0] dd, output mot_pkg::mot_rsp_s rr);
    rr = '0;
    @(posedge clk);
    cmd <= '{wr: w, rd: !w, page: pg, code: cd, data: dd};
    @(posedge clk);
    cmd.wr <= 1'b0;
    cmd.rd <= 1'b0;
    cmd.data <= ~dd;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      if (rsp.valid === 1'b1)
      begin
        rr = rsp;
        break;
      end
    end
  endtask : xfer
endmodule : mot_host_model
`default_nettype wire

// ### tb/mot_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mot_regs_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mot_pkg::mot_cmd_s cmd;
  mot_pkg::mot_rsp_s rsp, r;
  logic [1:0] men = '0, sen = '0, ovv = '0, uvv = '0, sclr = '0, ovf, uvf, lso, f;
  logic [1:0][15:0] nom = '0, raw = '0, up, lo, trep;
  logic [3:0][15:0] rv = {16'h0000, 16'hBA00, 16'h0000, 16'hCA80};
  logic [7:0] p, c;
  logic [15:0] d, n;
  int err_total = 0;
  int checks = 0;
  always #25 clk = ~clk;
  mot_regs u_mot_regs (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp), .margin_enable(men),
    .nominal_setpoint(nom), .upper_margin_voltage(up), .lower_margin_voltage(lo),
    .limit_sample_en(sen), .ov_violation(ovv), .uv_violation(uvv), .shutdown_clear(sclr),
    .ov_fault(ovf), .uv_fault(uvf), .low_side_on(lso), .external_sensor_temperature(raw),
    .external_temp_report(trep));
  mot_host_model u_mot_host_model (.clk(clk), .cmd(cmd), .rsp(rsp));
  ////////////////////////////////////////
  task automatic stop_test;
    $display("err_total=%0d checks=%0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic acc(input logic w, input logic [7:0] pg, input logic [7:0] cd,
                     input logic [15:0] dd);
    u_mot_host_model.xfer(w, pg, cd, dd, r);
    if (r.valid !== 1'b1)
    begin
      err_total++;
      stop_test();
    end
  endtask : acc
  // ov and uv see the same sample, so both faults must agree
  task automatic smp(input logic v);
    @(posedge clk);
    sen[0] <= 1'b1;
    ovv[0] <= v;
    uvv[0] <= v;
    @(posedge clk);
    sen[0] <= 1'b0;
    @(posedge clk);
    f = {ovf[0], uvf[0]};
  endtask : smp
  // every register of both outputs must read its reset word
  task automatic chk_rst;
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b0, 8'(i % 2), 8'hD7 + 8'(i / 2), 16'h0000);
      cmp("reset value", rv[i / 2], r.data);
    end
  endtask : chk_rst
  function automatic logic [15:0] exp_rd(input logic [7:0] cd, input logic [15:0] dd);
    return cd == 8'hD8 ? dd & 16'h008F : dd;
  endfunction : exp_rd
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(47));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk_rst();
    n = 16'($urandom % 4096);
    nom[0] <= n;
    repeat (2) @(posedge clk);
    cmp("upper off", n, up[0]);
    men[0] <= 1'b1;
    repeat (2) @(posedge clk);
    cmp("upper on", n + n / 20, up[0]);
    cmp("lower on", n - n / 20, lo[0]);
    raw[0] <= 16'h0190;
    repeat (2) @(posedge clk);
    cmp("temp unity", 16'h0190, trep[0]);
    acc(1'b1, 8'h00, 8'hD9, 16'h0002);
    acc(1'b1, 8'h00, 8'hDA, 16'h000A);
    repeat (2) @(posedge clk);
    cmp("temp scaled", 16'h0168, trep[0]);
    // output 1 still holds its reset settings
    nom[1] <= n;
    men[1] <= 1'b1;
    raw[1] <= 16'h0190;
    repeat (2) @(posedge clk);
    cmp("upper page1", n + n / 20, up[1]);
    cmp("lower page1", n - n / 20, lo[1]);
    cmp("temp page1", 16'h0190, trep[1]);
    // all-pages write lands on both outputs, all-pages read sees output 0
    acc(1'b1, 8'hFF, 8'hD9, 16'h0002);
    repeat (2) @(posedge clk);
    cmp("temp all pages", 16'h00C8, trep[1]);
    cmp("temp page0 kept", 16'h0168, trep[0]);
    acc(1'b1, 8'h01, 8'hD9, 16'h0004);
    acc(1'b0, 8'hFF, 8'hD9, 16'h0000);
    cmp("read all pages", 16'h0002, r.data);
    for (int m = 0; m < 2; m++)
    begin
      n = 16'($urandom % 4);
      acc(1'b1, 8'h00, 8'hD8, {8'h00, m[0], 3'b111, n[3:0]});
      for (int k = 0; k < 2 * n + 1; k++)
      begin
        smp(k != n);
        cmp("early fault", 16'h0000, 16'(f));
      end
      smp(1'b1);
      cmp("fault", 16'h0003, 16'(f));
      @(posedge clk);
      cmp("low side", 16'(m[0]), 16'(lso[0]));
      sclr[0] <= 1'b1;
      @(posedge clk);
      sclr[0] <= 1'b0;
      @(posedge clk);
      cmp("cleared", 16'h0000, 16'(lso[0]));
    end
    acc(1'b1, 8'h00, 8'hD6, 16'hFFFF);
    cmp("nack code", 16'h0001, 16'(r.nack));
    acc(1'b0, 8'h02, 8'hD7, 16'h0000);
    cmp("nack page", 16'h0001, 16'(r.nack));
    repeat (6)
    begin
      p = 8'($urandom % 2);
      c = 8'hD7 + 8'($urandom % 4);
      d = 16'($urandom);
      acc(1'b1, p, c, d);
      acc(1'b0, p, c, 16'h0000);
      cmp("readback", exp_rd(c, d), r.data);
    end
    // a reset in mid-run must restore every written register
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk_rst();
    cmp("temp after reset", 16'h0190, trep[1]);
    stop_test();
  end
endmodule : mot_regs_bench
`default_nettype wire

// ### tb/mot_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module mot_regs_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command port
  input wire mot_pkg::mot_cmd_s cmd,
  input wire mot_pkg::mot_rsp_s rsp,
  // margining
  input wire logic [1:0] margin_enable,
  input wire logic [1:0][15:0] nominal_setpoint,
  input wire logic [1:0][15:0] upper_margin_voltage,
  input wire logic [1:0][15:0] lower_margin_voltage,
  // faults
  input wire logic [1:0] limit_sample_en,
  input wire logic [1:0] ov_violation,
  input wire logic [1:0] shutdown_clear,
  input wire logic [1:0] ov_fault,
  input wire logic [1:0] low_side_on
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic req = cmd.wr | cmd.rd;
  a_rsp_answer: assert property (req |=> rsp.valid)
    else $error("no answer to request");
  a_rsp_quiet: assert property (!req |=> !rsp.valid)
    else $error("answer without request");
  a_nack_code: assert property (req && (cmd.code < 8'hD7 || cmd.code > 8'hDA)
    |=> rsp.nack && rsp.data == 16'h0000) else $error("bad code not refused");
  a_cfg_unused_zero: assert property (cmd.rd && cmd.code == 8'hD8
    |=> (rsp.data & 16'hFF70) == 16'h0000) else $error("unused config bits set");
  a_margin_off: assert property (!margin_enable[0]
    |=> upper_margin_voltage[0] == $past(nominal_setpoint[0])) else $error("margin while off");
  a_lower_margin_voltage: assert property (margin_enable[0]
    |=> lower_margin_voltage[0] <= $past(nominal_setpoint[0])) else $error("low margin above nom");
  a_fault_cause: assert property ($rose(ov_fault[0])
    |-> $past(limit_sample_en[0] && ov_violation[0])) else $error("fault without sample");
  a_fault_pulse: assert property (ov_fault[0] |=> !ov_fault[0])
    else $error("fault not a pulse");
  a_low_side_cause: assert property ($rose(low_side_on[0]) |-> $past(ov_fault[0]))
    else $error("low side on without fault");
  a_low_side_clear: assert property (shutdown_clear[0] && !ov_fault[0] |=> !low_side_on[0])
    else $error("low side not cleared");
endmodule : mot_regs_sva
bind mot_regs mot_regs_sva u_mot_regs_sva (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp),
  .margin_enable(margin_enable), .nominal_setpoint(nominal_setpoint),
  .upper_margin_voltage(upper_margin_voltage), .lower_margin_voltage(lower_margin_voltage),
  .limit_sample_en(limit_sample_en), .ov_violation(ov_violation),
  .shutdown_clear(shutdown_clear), .ov_fault(ov_fault), .low_side_on(low_side_on));
`default_nettype wire
